// [core/pmc_pkg.sv]
// pmc_pkg: offsets, field positions and reset values of the
// power-management capability register group.
// assumes byte-indexed configuration space reached in aligned dwords.
package pmc_pkg;
    // byte indices of the group
    localparam logic [7:0] PMC_OFF_CAP_ID    = 8'he0;
    localparam logic [7:0] PMC_OFF_NEXT_PTR  = 8'he1;
    localparam logic [7:0] PMC_OFF_CAPS      = 8'he2;
    localparam logic [7:0] PMC_OFF_CSR       = 8'he4;
    localparam logic [7:0] PMC_OFF_BRIDGE    = 8'he6;
    localparam logic [7:0] PMC_OFF_DATA      = 8'he7;
    localparam logic [7:0] PMC_OFF_ACPI_BASE = 8'he8;
    localparam logic [7:0] PMC_OFF_ACPI_MODE = 8'hea;
    // reset values
    localparam logic [7:0]  PMC_RST_CAP_ID    = 8'h01;
    localparam logic [7:0]  PMC_RST_NEXT_PTR  = 8'h00;
    localparam logic [15:0] PMC_RST_CAPS      = 16'h0000;
    localparam logic [15:0] PMC_RST_CSR       = 16'h0000;
    localparam logic [7:0]  PMC_RST_BRIDGE    = 8'h00;
    localparam logic [7:0]  PMC_RST_DATA      = 8'h00;
    localparam logic [15:0] PMC_RST_ACPI_BASE = 16'h0000;
    localparam logic [7:0]  PMC_RST_ACPI_MODE = 8'h00;
    // capability field positions
    localparam int PMC_CAP_WAKE_HI  = 15;
    localparam int PMC_CAP_WAKE_LO  = 11;
    localparam int PMC_CAP_D2_OK    = 10;
    localparam int PMC_CAP_D1_OK    = 9;
    localparam int PMC_CAP_DSI      = 5;
    localparam int PMC_CAP_AUX_PWR  = 4;
    localparam int PMC_CAP_CLK_DEP  = 3;
    localparam int PMC_CAP_VER_HI   = 2;
    // control/status field positions
    localparam int PMC_CSR_FLAG     = 15;
    localparam int PMC_CSR_SCALE_LO = 13;
    localparam int PMC_CSR_SEL_LO   = 9;
    localparam int PMC_CSR_EN       = 8;
    localparam int PMC_CSR_RSV_LO   = 2;
    // bridge extension bits
    localparam int PMC_BR_BUS_EN    = 7;
    localparam int PMC_BR_CLK_STOP  = 6;
    // power states
    localparam logic [1:0] PMC_D0     = 2'h0;
    localparam logic [1:0] PMC_D1     = 2'h1;
    localparam logic [1:0] PMC_D2     = 2'h2;
    localparam logic [1:0] PMC_D3HOT  = 2'h3;
    // acpi port response modes
    localparam logic [1:0] PMC_MODE_OFF   = 2'h0;
    localparam logic [1:0] PMC_MODE_SNOOP = 2'h1;
    localparam logic [1:0] PMC_MODE_CLAIM = 2'h2;
    // data selector depth
    localparam int PMC_SEL_W     = 4;
    localparam int PMC_DATA_ENTS = 16;
endpackage

// [core/pmc_acpi_port_decode.sv]
// pmc_acpi_port_decode: reacts to i/o accesses aimed at the acpi
// control port according to the programmed response mode.
// assumes one io_valid pulse per host i/o cycle, synchronous to ref_clk.
module pmc_acpi_port_decode
    import pmc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        io_valid,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    input  wire logic [15:0] port_base,
    input  wire logic [1:0]  port_mode,
    output logic             port_snoop,
    output logic             port_claim,
    output logic             port_forward
);
    logic hit; // address matches the programmed base
    assign hit = io_valid && (io_addr == port_base);

    // decision per cycle, all one-cycle pulses from flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_snoop   <= 1'b0;
            port_claim   <= 1'b0;
            port_forward <= 1'b0;
        end else begin
            // snoop only looks at writes and never blocks the cycle
            port_snoop   <= hit && io_write && (port_mode == PMC_MODE_SNOOP);
            port_claim   <= hit && (port_mode == PMC_MODE_CLAIM);
            // reserved mode behaves as disabled: safest is to pass the cycle on
            port_forward <= io_valid && !(hit && (port_mode == PMC_MODE_CLAIM));
        end
    end

    AST_CLAIM_NO_FWD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (hit && port_mode == PMC_MODE_CLAIM) |=> (port_claim && !port_forward))
        else $error("claimed port access was forwarded");
    AST_SNOOP_FWD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (hit && io_write && port_mode == PMC_MODE_SNOOP) |=> (port_snoop && port_forward))
        else $error("snooped write not forwarded");
endmodule // pmc_acpi_port_decode

// [core/pmc_regs.sv]
// pmc_regs: power-management capability registers of the bridge,
// reached by configuration reads and writes of aligned dwords.
// assumes lock-release bits live elsewhere and arrive as plain levels.
// Contract
// - capability id resets to 01h
// - lockable fields writable only when unlocked
// - next pointer holds following capability offset
// - wake-capable states field, bits 15 to 11
// - bits 10 and 9 report D2, D1
// - bit 5 flags device-specific initialisation
// - bit 4 selects auxiliary power source
// - bit 3 says wake needs pci clock
// - bits 2 to 0 give interface version
// - wake flag sets on event, write-one clears
// - control bit 8 gates wake output
// - selector 12-9 and scale 14-13 fields
// - power state field, D0 to D3hot
// - unsupported state writes dropped, bus completes
// - bus control off leaves secondary bus alone
// - D3hot removes power or stops clock
// - data register returns selected quantity
// - acpi port base, resets zero, relocatable
// - base writable only with second unlock
// - acpi port response mode decode
module pmc_regs
    import pmc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_rvalid,
    input  wire logic        lock_release,
    input  wire logic        acpi_base_unlock,
    input  wire logic        wake_event_in,
    input  wire logic        io_valid,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    output logic             wake_request_n,
    output logic             sec_bus_power_off,
    output logic             sec_bus_clock_stop,
    output logic             port_snoop,
    output logic             port_claim,
    output logic             port_forward
);
    // register storage
    logic [7:0]  cap_id_reg;        // capability identifier
    logic [7:0]  next_ptr_reg;      // next capability offset
    logic [15:0] caps_reg;          // capability flags
    logic [1:0]  pstate_reg;        // current power state
    logic [5:0]  csr_rsv_reg;       // locked reserved bits 7-2
    logic        wake_en_reg;       // wake_assert_enable
    logic [3:0]  data_sel_reg;      // data selector
    logic [1:0]  data_scale_reg;    // data scale
    logic        wake_flag_reg;     // wake_event_flag
    logic        wake_flag_next;    // flag after this edge
    logic        wake_en_next;      // enable after this edge
    logic [7:0]  bridge_ext_reg;    // bridge bus power extension
    logic [7:0]  data_tbl_reg [PMC_DATA_ENTS]; // per-selector data bytes
    logic [15:0] acpi_base_reg;     // acpi port base address
    logic [7:0]  acpi_mode_reg;     // acpi_port_response_mode and neighbours
    logic [31:0] rdata_next;        // read mux result

    // dword hit decode and per-lane write strobes
    logic        hit_id_dw;         // dword e0..e3
    logic        hit_csr_dw;        // dword e4..e7
    logic        hit_acpi_dw;       // dword e8..eb
    logic [3:0]  wr_id;             // lane strobes, dword e0
    logic [3:0]  wr_csr;            // lane strobes, dword e4
    logic [3:0]  wr_acpi;           // lane strobes, dword e8
    logic        state_ok;          // requested state is supported

    assign hit_id_dw   = (cfg_addr[7:2] == PMC_OFF_CAP_ID[7:2]);
    assign hit_csr_dw  = (cfg_addr[7:2] == PMC_OFF_CSR[7:2]);
    assign hit_acpi_dw = (cfg_addr[7:2] == PMC_OFF_ACPI_BASE[7:2]);
    assign wr_id   = {4{cfg_wr && hit_id_dw}} & cfg_be;
    assign wr_csr  = {4{cfg_wr && hit_csr_dw}} & cfg_be;
    assign wr_acpi = {4{cfg_wr && hit_acpi_dw}} & cfg_be;

    // optional states only when advertised; D0 and D3hot always accepted
    always_comb begin
        unique case (cfg_wdata[1:0])
            PMC_D1:  state_ok = caps_reg[PMC_CAP_D1_OK];
            PMC_D2:  state_ok = caps_reg[PMC_CAP_D2_OK];
            default: state_ok = 1'b1;
        endcase
    end

    // identifier, pointer and capability flags: all locked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_id_reg   <= PMC_RST_CAP_ID;
            next_ptr_reg <= PMC_RST_NEXT_PTR;
            caps_reg     <= PMC_RST_CAPS;
        end else if (lock_release) begin
            if (wr_id[0]) begin
                cap_id_reg <= cfg_wdata[7:0];
            end
            // software links the next capability here, zero ends the list
            if (wr_id[1]) begin
                next_ptr_reg <= cfg_wdata[15:8];
            end
            // low byte: dsi, aux power, clock dependency, version
            if (wr_id[2]) begin
                caps_reg[7:0] <= cfg_wdata[23:16];
            end
            // high byte: wake-capable states and D1/Second_low_state_ok
            if (wr_id[3]) begin
                caps_reg[15:8] <= cfg_wdata[31:24];
            end
        end
    end

    // power state: plain read/write, unsupported values silently dropped
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pstate_reg <= PMC_RST_CSR[1:0];
        end else if (wr_csr[0] && state_ok) begin
            pstate_reg <= cfg_wdata[1:0];
        end
    end

    // selector and enable are open; scale and reserved bits are locked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            csr_rsv_reg    <= PMC_RST_CSR[7:2];
            wake_en_reg    <= PMC_RST_CSR[PMC_CSR_EN];
            data_sel_reg   <= PMC_RST_CSR[12:9];
            data_scale_reg <= PMC_RST_CSR[14:13];
        end else begin
            if (wr_csr[0] && lock_release) begin
                csr_rsv_reg <= cfg_wdata[7:2];
            end
            wake_en_reg <= wake_en_next;
            if (wr_csr[1]) begin
                data_sel_reg <= cfg_wdata[PMC_CSR_SEL_LO +: PMC_SEL_W];
            end
            if (wr_csr[1] && lock_release) begin
                data_scale_reg <= cfg_wdata[PMC_CSR_SCALE_LO +: 2];
            end
        end
    end

    // wake flag: an event in the clearing cycle survives the clear
    always_comb begin
        wake_en_next   = wr_csr[1] ? cfg_wdata[PMC_CSR_EN] : wake_en_reg;
        wake_flag_next = wake_flag_reg;
        if (wr_csr[1] && cfg_wdata[PMC_CSR_FLAG]) begin
            wake_flag_next = 1'b0;
        end
        if (wake_event_in) begin
            wake_flag_next = 1'b1;
        end
    end

    // flag register and active-low wake pin, both updated together
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_flag_reg  <= PMC_RST_CSR[PMC_CSR_FLAG];
            wake_request_n <= 1'b1;
        end else begin
            wake_flag_reg  <= wake_flag_next;
            wake_request_n <= !(wake_flag_next && wake_en_next);
        end
    end

    // bridge extension byte: locked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bridge_ext_reg <= PMC_RST_BRIDGE;
        end else if (wr_csr[2] && lock_release) begin
            bridge_ext_reg <= cfg_wdata[23:16];
        end
    end

    // secondary bus control follows the state one cycle later
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sec_bus_power_off  <= 1'b0;
            sec_bus_clock_stop <= 1'b0;
        end else begin
            // with the mechanism disabled the state field has no effect
            sec_bus_power_off  <= bridge_ext_reg[PMC_BR_BUS_EN]
                                  && (pstate_reg == PMC_D3HOT)
                                  && !bridge_ext_reg[PMC_BR_CLK_STOP];
            sec_bus_clock_stop <= bridge_ext_reg[PMC_BR_BUS_EN]
                                  && (pstate_reg == PMC_D3HOT)
                                  && bridge_ext_reg[PMC_BR_CLK_STOP];
        end
    end

    // data table: one byte per selector value, written when unlocked
    genvar gi;
    generate
        for (gi = 0; gi < PMC_DATA_ENTS; gi++) begin : g_data
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    data_tbl_reg[gi] <= PMC_RST_DATA;
                end else if (wr_csr[3] && lock_release
                             && (data_sel_reg == PMC_SEL_W'(gi))) begin
                    data_tbl_reg[gi] <= cfg_wdata[31:24];
                end
            end
        end
    endgenerate

    // acpi port base needs its own unlock; mode byte is always open
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acpi_base_reg <= PMC_RST_ACPI_BASE;
            acpi_mode_reg <= PMC_RST_ACPI_MODE;
        end else begin
            if (wr_acpi[0] && acpi_base_unlock) begin
                acpi_base_reg[7:0] <= cfg_wdata[7:0];
            end
            if (wr_acpi[1] && acpi_base_unlock) begin
                acpi_base_reg[15:8] <= cfg_wdata[15:8];
            end
            if (wr_acpi[2]) begin
                acpi_mode_reg <= cfg_wdata[23:16];
            end
        end
    end

    // read mux; unmapped dwords and byte eb read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_id_dw) begin
            rdata_next = {caps_reg, next_ptr_reg, cap_id_reg};
        end else if (hit_csr_dw) begin
            rdata_next = {data_tbl_reg[data_sel_reg], bridge_ext_reg,
                          wake_flag_reg, data_scale_reg, data_sel_reg,
                          wake_en_reg, csr_rsv_reg, pstate_reg};
        end else if (hit_acpi_dw) begin
            rdata_next = {8'h00, acpi_mode_reg, acpi_base_reg};
        end
    end

    // read answer one cycle after the request; data held until next read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= rdata_next;
            end
        end
    end

    // port decoder driven by programmed base and mode
    pmc_acpi_port_decode u_port (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .io_valid     (io_valid),
        .io_write     (io_write),
        .io_addr      (io_addr),
        .port_base    (acpi_base_reg),
        .port_mode    (acpi_mode_reg[1:0]),
        .port_snoop   (port_snoop),
        .port_claim   (port_claim),
        .port_forward (port_forward)
    );

    // checks
    sequence s_csr_read;
        cfg_rd && hit_csr_dw;
    endsequence
    sequence s_d3_b3;
        bridge_ext_reg[PMC_BR_BUS_EN] && !bridge_ext_reg[PMC_BR_CLK_STOP]
        && pstate_reg == PMC_D3HOT;
    endsequence

    AST_ID_LOCKED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !lock_release |=> $stable(cap_id_reg) && $stable(caps_reg))
        else $error("locked register changed");
    AST_ID_RESET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cap_id_reg != PMC_RST_CAP_ID) |-> $past(lock_release) || $stable(cap_id_reg))
        else $error("capability id left reset value without unlock");
    AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wake_event_in |=> wake_flag_reg)
        else $error("wake event did not set flag");
    AST_FLAG_CLR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (wr_csr[1] && cfg_wdata[PMC_CSR_FLAG] && !wake_event_in) |=> !wake_flag_reg)
        else $error("write one did not clear flag");
    AST_WAKE_PIN: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wake_request_n == !(wake_flag_reg && wake_en_reg))
        else $error("wake pin disagrees with flag and enable");
    AST_STATE_DROP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (wr_csr[0] && ((cfg_wdata[1:0] == PMC_D1 && !caps_reg[PMC_CAP_D1_OK])
                    || (cfg_wdata[1:0] == PMC_D2 && !caps_reg[PMC_CAP_D2_OK])))
        |=> $stable(pstate_reg))
        else $error("unsupported state accepted");
    AST_B3: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_d3_b3 |=> sec_bus_power_off && !sec_bus_clock_stop)
        else $error("D3hot did not remove secondary power");
    AST_BUS_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !bridge_ext_reg[PMC_BR_BUS_EN] |=> !sec_bus_power_off && !sec_bus_clock_stop)
        else $error("secondary bus touched with control disabled");
    AST_BASE_LOCK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !acpi_base_unlock |=> $stable(acpi_base_reg))
        else $error("acpi base changed while locked");
    AST_DATA_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_csr_read ##1 cfg_rvalid |-> cfg_rdata[31:24] == $past(data_tbl_reg[data_sel_reg]))
        else $error("data byte does not follow selector");
endmodule // pmc_regs

// [tb/pmc_lock_model.sv]
// pmc_lock_model: the lock byte at index 90h that sits outside the block.
// assumes the bench writes it whole; only bits 5 and 2 leave the model.
module pmc_lock_model (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       lock_wr,
    input  wire logic [7:0] lock_wdata,
    output logic            lock_release,
    output logic            acpi_base_unlock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] lock_reg; // index 90h contents, locked after reset
    // written by configuration software, cleared by system reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_reg <= 8'h00;
        end else if (lock_wr) begin
            lock_reg <= lock_wdata;
        end
    end
    assign lock_release     = lock_reg[5];
    assign acpi_base_unlock = lock_reg[2];
endmodule // pmc_lock_model

// [tb/pmc_regs_tb.sv]
// pmc_regs_tb: self-checking bench for the power-management registers.
// assumes inputs driven on the falling edge, outputs judged there too.
module pmc_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pmc_pkg::*;
    logic        ref_clk, arst_n, cfg_wr, cfg_rd, cfg_rvalid, lock_wr;
    logic [7:0]  cfg_addr, lock_wdata;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    logic        lock_release, acpi_base_unlock, wake_event_in, io_valid, io_write;
    logic [15:0] io_addr;
    logic        wake_request_n, sec_bus_power_off, sec_bus_clock_stop;
    logic        port_snoop, port_claim, port_forward;
    int          error_cnt = 0;
    int          num_checks = 0;

    pmc_regs pmc_regs_i (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .lock_release(lock_release),
        .acpi_base_unlock(acpi_base_unlock), .wake_event_in(wake_event_in),
        .io_valid(io_valid), .io_write(io_write), .io_addr(io_addr),
        .wake_request_n(wake_request_n), .sec_bus_power_off(sec_bus_power_off),
        .sec_bus_clock_stop(sec_bus_clock_stop), .port_snoop(port_snoop),
        .port_claim(port_claim), .port_forward(port_forward));
    pmc_lock_model pmc_lock_model_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .lock_wr(lock_wr), .lock_wdata(lock_wdata), .lock_release(lock_release),
        .acpi_base_unlock(acpi_base_unlock));

    // free-running 100 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // verdict and end of run, the only exit
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one comparison, four-state exact
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // one-cycle write strobe, taken at the rising edge between negedges
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge ref_clk);
        cfg_wr = 1'b1; cfg_addr = a; cfg_be = be; cfg_wdata = d;
        @(negedge ref_clk);
        cfg_wr = 1'b0; cfg_wdata = ~d; // stale data must not matter
    endtask
    // read strobe, answer expected one cycle later; bounded wait
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
        int i;
        @(negedge ref_clk);
        cfg_rd = 1'b1; cfg_addr = a;
        @(negedge ref_clk);
        cfg_rd = 1'b0;
        for (i = 0; i < 4 && cfg_rvalid !== 1'b1; i++) @(negedge ref_clk);
        if (cfg_rvalid !== 1'b1) begin
            error_cnt++;
            $display("FAIL rvalid expected 1 seen %b", cfg_rvalid);
            stop_test();
        end
        d = cfg_rdata;
    endtask
    // whole lock byte; bit 5 frees locked fields, bit 2 the port base
    task automatic set_lock(input logic [7:0] v);
        @(negedge ref_clk);
        lock_wr = 1'b1; lock_wdata = v;
        @(negedge ref_clk);
        lock_wr = 1'b0;
    endtask

    // reset values and unmapped space
    task automatic t_reset();
        cfg_read(PMC_OFF_CAP_ID, rd); check("id_next_caps", rd, 32'h0000_0001);
        cfg_read(PMC_OFF_CSR, rd); check("csr_block", rd, 32'h0000_0000);
        cfg_read(PMC_OFF_ACPI_BASE, rd); check("acpi_block", rd, 32'h0000_0000);
        cfg_read(8'hf0, rd); check("unmapped", rd, 32'h0000_0000);
    endtask
    // locked writes dropped, then accepted once released
    task automatic t_lock_caps();
        cfg_write(PMC_OFF_CAP_ID, 4'hf, 32'hffff_ffff);
        cfg_read(PMC_OFF_CAP_ID, rd); check("locked_caps", rd, 32'h0000_0001);
        set_lock(8'h20);
        // d1 supported, d2 not, dsi, aux, clock bits set, version 1
        cfg_write(PMC_OFF_CAP_ID, 4'hf, 32'hfa39_e801);
        cfg_read(PMC_OFF_CAP_ID, rd); check("caps_word", rd, 32'hfa39_e801);
        check("first_low_state_ok", rd[16+PMC_CAP_D1_OK], 1'b1);
        set_lock(8'h00);
    endtask
    // state writes: unsupported d2 dropped, d1 and d3hot taken
    task automatic t_state();
        cfg_write(PMC_OFF_CSR, 4'h1, {30'h0, PMC_D2});
        cfg_read(PMC_OFF_CSR, rd); check("state_d2_drop", rd[1:0], PMC_D0);
        check("rvalid_drop", cfg_rvalid, 1'b1);
        cfg_write(PMC_OFF_CSR, 4'h1, {30'h0, PMC_D1});
        cfg_read(PMC_OFF_CSR, rd); check("state_d1", rd[1:0], PMC_D1);
        cfg_write(PMC_OFF_CSR, 4'h1, {30'h0, PMC_D3HOT});
        cfg_read(PMC_OFF_CSR, rd); check("state_d3", rd[1:0], PMC_D3HOT);
    endtask
    // secondary bus only follows d3hot when bus control is on
    task automatic t_sec_bus();
        tick(2);
        check("off_no_ctl", {sec_bus_power_off, sec_bus_clock_stop}, 2'b00);
        set_lock(8'h20);
        cfg_write(PMC_OFF_CSR, 4'h4, 32'h0080_0000);
        tick(2);
        check("power_off", {sec_bus_power_off, sec_bus_clock_stop}, 2'b10);
        cfg_write(PMC_OFF_CSR, 4'h4, 32'h00c0_0000);
        tick(2);
        check("clock_stop", {sec_bus_power_off, sec_bus_clock_stop}, 2'b01);
        cfg_write(PMC_OFF_CSR, 4'h1, {30'h0, PMC_D0});
        tick(2);
        check("d0_bus_on", {sec_bus_power_off, sec_bus_clock_stop}, 2'b00);
    endtask
    // flag sets regardless of enable, pin gated, write-one clears
    task automatic t_wake();
        @(negedge ref_clk) wake_event_in = 1'b1;
        @(negedge ref_clk) wake_event_in = 1'b0;
        check("pin_disabled", wake_request_n, 1'b1);
        cfg_read(PMC_OFF_CSR, rd); check("flag_set", rd[PMC_CSR_FLAG], 1'b1);
        cfg_write(PMC_OFF_CSR, 4'h2, 32'h0000_0100);
        check("pin_enabled", wake_request_n, 1'b0);
        cfg_read(PMC_OFF_CSR, rd); check("flag_w0", rd[PMC_CSR_FLAG], 1'b1);
        // event standing across the clearing write: the set must win
        wake_event_in = 1'b1;
        cfg_write(PMC_OFF_CSR, 4'h2, 32'h0000_8100);
        wake_event_in = 1'b0;
        check("set_beats_clr", wake_request_n, 1'b0);
        cfg_write(PMC_OFF_CSR, 4'h2, 32'h0000_8100);
        check("pin_cleared", wake_request_n, 1'b1);
        cfg_read(PMC_OFF_CSR, rd); check("flag_clr", rd[PMC_CSR_FLAG], 1'b0);
        cfg_write(PMC_OFF_CSR, 4'h2, 32'h0000_0000);
    endtask
    // data byte follows the selector; scale stored while unlocked
    task automatic t_data();
        // the data lane indexes by the selector already stored, so select first
        cfg_write(PMC_OFF_CSR, 4'h2, 32'h0000_6600); // scale 3, select 3
        cfg_write(PMC_OFF_CSR, 4'h8, 32'h5a00_0000); // entry 3
        cfg_write(PMC_OFF_CSR, 4'h2, 32'h0000_0a00); // select 5
        cfg_write(PMC_OFF_CSR, 4'h8, 32'ha500_0000); // entry 5
        cfg_read(PMC_OFF_CSR, rd); check("data_sel5", rd[31:24], 8'ha5);
        cfg_write(PMC_OFF_CSR, 4'h2, 32'h0000_6600);
        cfg_read(PMC_OFF_CSR, rd); check("data_sel3", rd[31:24], 8'h5a);
        check("scale_sel", rd[14:9], 6'h33);
        set_lock(8'h00);
        // locked: data byte and scale keep their values, selector still open
        cfg_write(PMC_OFF_CSR, 4'ha, 32'hff00_0600);
        cfg_read(PMC_OFF_CSR, rd); check("data_locked", rd[31:24], 8'h5a);
        check("scale_locked", rd[14:9], 6'h33);
    endtask
    // port base needs its own unlock; every response mode once on a hit, then a miss in claim mode
    task automatic t_acpi();
        logic [1:0] m;
        cfg_write(PMC_OFF_ACPI_BASE, 4'h3, 32'h0000_1234);
        cfg_read(PMC_OFF_ACPI_BASE, rd); check("base_locked", rd[15:0], 16'h0000);
        set_lock(8'h04);
        cfg_write(PMC_OFF_ACPI_BASE, 4'h3, 32'h0000_1234);
        cfg_read(PMC_OFF_ACPI_BASE, rd); check("base_moved", rd[15:0], 16'h1234);
        for (int k = 0; k < 5; k++) begin
            m = (k == 4) ? PMC_MODE_CLAIM : k[1:0];
            cfg_write(PMC_OFF_ACPI_BASE, 4'h4, {14'h0, m, 16'h0});
            @(negedge ref_clk);
            io_valid = 1'b1; io_write = 1'b1; io_addr = (k == 4) ? 16'h1235 : 16'h1234;
            @(negedge ref_clk) io_valid = 1'b0;
            if (k == 4) check("miss_fwd", {port_snoop, port_claim, port_forward}, 3'b001);
            else check("mode_resp", {port_snoop, port_claim, port_forward},
                {m == PMC_MODE_SNOOP, m == PMC_MODE_CLAIM, m != PMC_MODE_CLAIM});
        end
    endtask

    // reset for 12 cycles, then every scenario in turn
    initial begin
        arst_n = 1'b0; cfg_wr = 1'b0; cfg_rd = 1'b0; cfg_addr = 8'h00; cfg_be = 4'h0;
        cfg_wdata = 32'h0; lock_wr = 1'b0; lock_wdata = 8'h00; wake_event_in = 1'b0;
        io_valid = 1'b0; io_write = 1'b0; io_addr = 16'h0;
        tick(12);
        arst_n = 1'b1;
        check("pin_reset", wake_request_n, 1'b1);
        t_reset();
        t_lock_caps();
        t_state();
        t_sec_bus();
        t_wake();
        t_data();
        t_acpi();
        stop_test();
    end
endmodule // pmc_regs_tb
